// file: cpm_pkg.sv
// Constants, types and carriers for the CPU programming-model block.
// Assumes one 40 MHz clock and a reset controller on the same clock.
//
// What this block does
// - Two 8-bit accumulators; paired as 16 bits, first one is upper byte.
// - Add second accumulator to x or y pointer; no first-accumulator form.
// - Flag copy both ways and decimal adjust exist only for first accumulator.
// - Accumulator add, subtract, compare: second is source, first is destination.
// - Indexed address is index register plus unsigned 8-bit offset.
// - Y-pointer indexed address and second-accumulator add cost one extra byte and one extra cycle.
// - Stack pointer addresses next free byte; decrement after push, increment before pull.
// - Subroutine call pushes return address low byte first; return pulls it.
// - Interrupt finishes instruction, pushes return address, Y and X pointers, both accumulators, flags, then vectors.
// - Interrupt return pulls registers in reverse order, then resumes at return address.
// - Reset loads program counter from one of six vector pairs by mode and cause.
// - Flags register holds C V Z N H, two interrupt masks, stop disable.
// - Load or store of first accumulator sets N and Z, clears V.
// - Push, pull, pointer adds and flags-to-accumulator copy leave all flags unchanged.
// - Carry from arithmetic, bit 7 of multiply's low byte, shifted through by rotates.
// - Overflow set on arithmetic overflow, cleared otherwise.
// - Zero set on zero result; compare subtracts without storing, sets flags.
// - Index increment or decrement changes only the zero flag.
// - One 64-Kbyte address space for memory and peripherals, no I/O strobes.
// - External operands take the same time as internal ones.
// - Negative flag copies the result's most significant bit.
// - Maskable mask set by reset, cleared by software, set after stacking.
// - Nonmaskable mask set only by reset or its acknowledge; cleared by copy or return.
// - Stop disable set by reset; while set a stop instruction does nothing.
`default_nettype none

package cpm_pkg;

	localparam logic [3:0]  REG_ACC_FIRST  = 4'h0;
	localparam logic [3:0]  REG_ACC_SECOND = 4'h1;
	localparam logic [3:0]  REG_X_POINTER  = 4'h2;
	localparam logic [3:0]  REG_Y_POINTER  = 4'h3;
	localparam logic [3:0]  REG_STACK      = 4'h4;
	localparam logic [3:0]  REG_PROG_CNT   = 4'h5;
	localparam logic [3:0]  REG_FLAGS      = 4'h6;
	localparam logic [3:0]  REG_STATUS     = 4'h7;

	localparam int FLAG_C = 0;
	localparam int FLAG_V = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_N = 3;
	localparam int FLAG_I = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_X = 6;
	localparam int FLAG_S = 7;

	localparam logic [7:0]  FLAGS_RST  = 8'hd0;
	localparam logic [7:0]  BYTE_RST   = 8'h00;
	localparam logic [15:0] WORD_RST   = 16'h0000;

	localparam logic [15:0] VEC_NORM_POR = 16'hfffe;
	localparam logic [15:0] VEC_NORM_CLK = 16'hfffc;
	localparam logic [15:0] VEC_NORM_COP = 16'hfffa;
	localparam logic [15:0] VEC_SPEC_POR = 16'hbffe;
	localparam logic [15:0] VEC_SPEC_CLK = 16'hbffc;
	localparam logic [15:0] VEC_SPEC_COP = 16'hbffa;

	localparam logic [3:0] SLOT_CCR = 4'h0;
	localparam logic [3:0] SLOT_B   = 4'h1;
	localparam logic [3:0] SLOT_A   = 4'h2;
	localparam logic [3:0] SLOT_XH  = 4'h3;
	localparam logic [3:0] SLOT_XL  = 4'h4;
	localparam logic [3:0] SLOT_YH  = 4'h5;
	localparam logic [3:0] SLOT_YL  = 4'h6;
	localparam logic [3:0] SLOT_PH  = 4'h7;
	localparam logic [3:0] SLOT_PL  = 4'h8;

	localparam logic [3:0] LEN_INT  = 4'h9;
	localparam logic [3:0] LEN_SUB  = 4'h2;
	localparam logic [3:0] LEN_ONE  = 4'h1;
	localparam logic [3:0] VEC_DONE = 4'h2;

	typedef enum logic [1:0] {
		CAUSE_POR_PIN = 2'b00,
		CAUSE_CLK_MON = 2'b01,
		CAUSE_WATCHDOG = 2'b10
	} cpm_cause_t;

	typedef enum logic [4:0] {
		OP_NOP      = 5'b00000,
		OP_LOAD_A   = 5'b00001,
		OP_STORE_A  = 5'b00010,
		OP_ADD_A    = 5'b00011,
		OP_ADD_BA   = 5'b00100,
		OP_SUB_BA   = 5'b00101,
		OP_CMP_BA   = 5'b00110,
		OP_ADD_BX   = 5'b00111,
		OP_ADD_BY   = 5'b01000,
		OP_A_TO_F   = 5'b01001,
		OP_F_TO_A   = 5'b01010,
		OP_DEC_ADJ  = 5'b01011,
		OP_INC_X    = 5'b01100,
		OP_DEC_X    = 5'b01101,
		OP_INC_Y    = 5'b01110,
		OP_DEC_Y    = 5'b01111,
		OP_EA_X     = 5'b10000,
		OP_EA_Y     = 5'b10001,
		OP_PUSH_A   = 5'b10010,
		OP_PULL_A   = 5'b10011,
		OP_JUMP_SUB = 5'b10100,
		OP_BRAN_SUB = 5'b10101,
		OP_RET_SUB  = 5'b10110,
		OP_INT_MASK = 5'b10111,
		OP_INT_NMI  = 5'b11000,
		OP_RET_INT  = 5'b11001,
		OP_STOP     = 5'b11010,
		OP_ADV_PC   = 5'b11011,
		OP_ROR_A    = 5'b11100,
		OP_ROL_A    = 5'b11101,
		OP_MUL      = 5'b11110
	} cpm_op_t;

	typedef enum logic [2:0] {
		ST_BOOT = 3'b000,
		ST_VEC  = 3'b001,
		ST_IDLE = 3'b010,
		ST_PUSH = 3'b011,
		ST_PULL = 3'b100,
		ST_EA_Y = 3'b101
	} cpm_state_t;

	typedef struct packed {
		cpm_op_t     op;
		logic [15:0] data;
	} cpm_cmd_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} cpm_mem_t;

	typedef struct packed {
		logic [7:0] res;
		logic       h;
		logic       v;
		logic       c;
	} cpm_alu_t;

endpackage

`default_nettype wire

// file: cpm_programming_model.sv
// CPU programming model: registers, flags, stack sequencer, reset vectors.
// Assumes memory answers a read in the next cycle, and a same-clock sequencer
// that issues one command at a time and holds it until cmd_ready_o.
`timescale 1ns/100ps
`default_nettype none

module cpm_programming_model
	import cpm_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	input  wire logic        reg_we_i,
	input  wire logic        reg_re_i,
	output logic      [15:0] reg_rdata_o,
	input  wire logic        cmd_valid_i,
	input  wire cpm_cmd_t    cmd_i,
	output logic             cmd_ready_o,
	input  wire logic        special_mode_i,
	input  wire cpm_cause_t  reset_cause_i,
	output cpm_mem_t         mem_o,
	input  wire logic [7:0]  mem_rdata_i,
	output logic      [15:0] ea_o,
	output logic             ea_valid_o,
	output logic             stop_o,
	output logic      [7:0]  flags_o,
	output logic      [15:0] acc_pair_o
);

	logic [7:0]  a_q, a_d, b_q, b_d, ccr_q, ccr_d;
	logic [15:0] ix_q, ix_d, iy_q, iy_d, sp_q, sp_d, pc_q, pc_d;
	logic [15:0] tgt_q, tgt_d, ea_q, ea_d, rdata_q, rdata_d;
	logic [3:0]  cnt_q, cnt_d;
	logic        ea_v_q, ea_v_d, stop_q, stop_d;
	cpm_state_t  st_q, st_d;
	cpm_op_t     kind_q, kind_d;
	cpm_mem_t    mem_c;
	cpm_alu_t    alu;
	logic        take;
	logic [15:0] prod;
	logic [7:0]  daa_fix, byte_v;

	function automatic cpm_alu_t add8(input logic [7:0] x, input logic [7:0] y,
		input logic cin, input logic sub);
		cpm_alu_t r;
		logic [8:0] s;
		logic [4:0] hs;
		if (sub)
		begin
			s = {1'b0, x} - {1'b0, y} - {8'h00, cin};
			hs = 5'h00;
			r.res = s[7:0];
			r.c = (~x[7] & y[7]) | (y[7] & r.res[7]) | (r.res[7] & ~x[7]);
			r.v = (x[7] & ~y[7] & ~r.res[7]) | (~x[7] & y[7] & r.res[7]);
		end
		else
		begin
			s = {1'b0, x} + {1'b0, y} + {8'h00, cin};
			hs = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
			r.res = s[7:0];
			r.c = s[8];
			r.v = (x[7] & y[7] & ~r.res[7]) | (~x[7] & ~y[7] & r.res[7]);
		end
		r.h = hs[4];
		return r;
	endfunction

	// Sets N and Z from a result, leaves the other bits to the caller
	function automatic logic [7:0] nz(input logic [7:0] f, input logic [7:0] res);
		logic [7:0] o;
		o = f;
		o[FLAG_N] = res[7];
		o[FLAG_Z] = (res == BYTE_RST);
		return o;
	endfunction

	function automatic logic [3:0] stack_len(input cpm_op_t k);
		logic [3:0] n;
		unique case (k)
			OP_INT_MASK, OP_INT_NMI, OP_RET_INT: n = LEN_INT;
			OP_JUMP_SUB, OP_BRAN_SUB, OP_RET_SUB: n = LEN_SUB;
			default: n = LEN_ONE;
		endcase
		return n;
	endfunction

	// Which register byte the idx-th stacked byte of a sequence is
	function automatic logic [3:0] slot_of(input cpm_op_t k, input logic [3:0] idx);
		logic [3:0] s;
		unique case (k)
			OP_INT_MASK, OP_INT_NMI, OP_JUMP_SUB, OP_BRAN_SUB: s = SLOT_PL - idx;
			OP_RET_INT: s = SLOT_CCR + idx;
			OP_RET_SUB: s = SLOT_PH + idx;
			default: s = SLOT_A;
		endcase
		return s;
	endfunction

	function automatic logic [15:0] reset_vector(input logic spec, input cpm_cause_t c);
		logic [15:0] v;
		unique case (c)
			CAUSE_CLK_MON: v = spec ? VEC_SPEC_CLK : VEC_NORM_CLK;
			CAUSE_WATCHDOG: v = spec ? VEC_SPEC_COP : VEC_NORM_COP;
			default: v = spec ? VEC_SPEC_POR : VEC_NORM_POR;
		endcase
		return v;
	endfunction

	always_comb
	begin
		logic [3:0] sl;
		logic [7:0] pushed;
		sl = slot_of(kind_q, cnt_q);
		unique case (sl)
			SLOT_CCR: pushed = ccr_q;
			SLOT_B: pushed = b_q;
			SLOT_A: pushed = a_q;
			SLOT_XH: pushed = ix_q[15:8];
			SLOT_XL: pushed = ix_q[7:0];
			SLOT_YH: pushed = iy_q[15:8];
			SLOT_YL: pushed = iy_q[7:0];
			SLOT_PH: pushed = pc_q[15:8];
			default: pushed = pc_q[7:0];
		endcase
		a_d = a_q;
		b_d = b_q;
		ix_d = ix_q;
		iy_d = iy_q;
		sp_d = sp_q;
		pc_d = pc_q;
		ccr_d = ccr_q;
		tgt_d = tgt_q;
		ea_d = ea_q;
		ea_v_d = 1'b0;
		stop_d = stop_q;
		st_d = st_q;
		cnt_d = cnt_q;
		kind_d = kind_q;
		mem_c = '0;
		alu = '0;
		prod = WORD_RST;
		daa_fix = BYTE_RST;
		byte_v = cmd_i.data[7:0];
		take = 1'b0;
		unique case (st_q)
			ST_BOOT:
			begin
				tgt_d = reset_vector(special_mode_i, reset_cause_i);
				cnt_d = '0;
				st_d = ST_VEC;
			end
			ST_VEC:
			begin
				// Vector word: high byte at the lower address, one read per cycle
				if (cnt_q != VEC_DONE)
				begin
					mem_c.rd = 1'b1;
					mem_c.addr = tgt_q + {12'h000, cnt_q};
				end
				if (cnt_q == LEN_ONE)
					pc_d[15:8] = mem_rdata_i;
				if (cnt_q == VEC_DONE)
				begin
					pc_d[7:0] = mem_rdata_i;
					st_d = ST_IDLE;
				end
				cnt_d = cnt_q + LEN_ONE;
			end
			ST_PUSH:
			begin
				mem_c.wr = 1'b1;
				mem_c.addr = sp_q;
				mem_c.wdata = pushed;
				sp_d = sp_q - 16'h0001;
				cnt_d = cnt_q + LEN_ONE;
				if (cnt_q == stack_len(kind_q) - LEN_ONE)
				begin
					st_d = ST_IDLE;
					if (kind_q == OP_INT_MASK || kind_q == OP_INT_NMI)
					begin
						ccr_d[FLAG_I] = 1'b1;
						if (kind_q == OP_INT_NMI)
							ccr_d[FLAG_X] = 1'b1;
						cnt_d = '0;
						st_d = ST_VEC;
					end
					else if (kind_q != OP_PUSH_A)
						pc_d = tgt_q;
				end
			end
			ST_PULL:
			begin
				// Read issued at sp+1 while the previous byte is captured
				if (cnt_q != stack_len(kind_q))
				begin
					mem_c.rd = 1'b1;
					mem_c.addr = sp_q + 16'h0001;
					sp_d = sp_q + 16'h0001;
				end
				else
					st_d = ST_IDLE;
				if (cnt_q != '0)
				begin
					unique case (slot_of(kind_q, cnt_q - LEN_ONE))
						SLOT_CCR:
						begin
							ccr_d = mem_rdata_i;
							ccr_d[FLAG_X] = ccr_q[FLAG_X] & mem_rdata_i[FLAG_X];
						end
						SLOT_B: b_d = mem_rdata_i;
						SLOT_A: a_d = mem_rdata_i;
						SLOT_XH: ix_d[15:8] = mem_rdata_i;
						SLOT_XL: ix_d[7:0] = mem_rdata_i;
						SLOT_YH: iy_d[15:8] = mem_rdata_i;
						SLOT_YL: iy_d[7:0] = mem_rdata_i;
						SLOT_PH: pc_d[15:8] = mem_rdata_i;
						default: pc_d[7:0] = mem_rdata_i;
					endcase
				end
				cnt_d = cnt_q + LEN_ONE;
			end
			ST_EA_Y:
			begin
				ea_v_d = 1'b1;
				st_d = ST_IDLE;
			end
			default:
			begin
				take = cmd_valid_i && !reg_we_i;
				if (take)
				begin
					stop_d = 1'b0;
					kind_d = cmd_i.op;
					cnt_d = '0;
					unique case (cmd_i.op)
						OP_LOAD_A:
						begin
							a_d = byte_v;
							ccr_d = nz(ccr_q, byte_v);
							ccr_d[FLAG_V] = 1'b0;
						end
						OP_STORE_A:
						begin
							mem_c.wr = 1'b1;
							mem_c.addr = cmd_i.data;
							mem_c.wdata = a_q;
							ccr_d = nz(ccr_q, a_q);
							ccr_d[FLAG_V] = 1'b0;
						end
						OP_ADD_A, OP_ADD_BA:
						begin
							alu = add8(a_q, (cmd_i.op == OP_ADD_A) ? byte_v : b_q, 1'b0, 1'b0);
							a_d = alu.res;
							ccr_d = nz(ccr_q, alu.res);
							ccr_d[FLAG_H] = alu.h;
							ccr_d[FLAG_V] = alu.v;
							ccr_d[FLAG_C] = alu.c;
						end
						OP_SUB_BA, OP_CMP_BA:
						begin
							alu = add8(a_q, b_q, 1'b0, 1'b1);
							if (cmd_i.op == OP_SUB_BA)
								a_d = alu.res;
							ccr_d = nz(ccr_q, alu.res);
							ccr_d[FLAG_V] = alu.v;
							ccr_d[FLAG_C] = alu.c;
						end
						OP_ADD_BX: ix_d = ix_q + {8'h00, b_q};
						OP_ADD_BY: st_d = ST_EA_Y;
						OP_A_TO_F:
						begin
							ccr_d = a_q;
							ccr_d[FLAG_X] = ccr_q[FLAG_X] & a_q[FLAG_X];
						end
						OP_F_TO_A: a_d = ccr_q;
						OP_DEC_ADJ:
						begin
							if (ccr_q[FLAG_H] || a_q[3:0] > 4'h9)
								daa_fix[3:0] = 4'h6;
							if (ccr_q[FLAG_C] || a_q > 8'h99)
								daa_fix[7:4] = 4'h6;
							alu = add8(a_q, daa_fix, 1'b0, 1'b0);
							a_d = alu.res;
							ccr_d = nz(ccr_q, alu.res);
							ccr_d[FLAG_C] = ccr_q[FLAG_C] | alu.c | daa_fix[5];
						end
						OP_INC_X: ix_d = ix_q + 16'h0001;
						OP_DEC_X: ix_d = ix_q - 16'h0001;
						OP_INC_Y: iy_d = iy_q + 16'h0001;
						OP_DEC_Y: iy_d = iy_q - 16'h0001;
						OP_EA_X:
						begin
							ea_d = ix_q + {8'h00, byte_v};
							ea_v_d = 1'b1;
						end
						OP_EA_Y:
						begin
							ea_d = iy_q + {8'h00, byte_v};
							st_d = ST_EA_Y;
						end
						OP_PUSH_A, OP_INT_MASK, OP_INT_NMI:
						begin
							tgt_d = cmd_i.data;
							st_d = ST_PUSH;
						end
						OP_JUMP_SUB:
						begin
							tgt_d = cmd_i.data;
							st_d = ST_PUSH;
						end
						OP_BRAN_SUB:
						begin
							tgt_d = pc_q + {{8{byte_v[7]}}, byte_v};
							st_d = ST_PUSH;
						end
						OP_PULL_A, OP_RET_SUB, OP_RET_INT: st_d = ST_PULL;
						OP_STOP: stop_d = !ccr_q[FLAG_S];
						OP_ADV_PC: pc_d = pc_q + {13'h0000, cmd_i.data[2:0]};
						OP_ROR_A, OP_ROL_A:
						begin
							if (cmd_i.op == OP_ROR_A)
								{a_d, ccr_d[FLAG_C]} = {ccr_q[FLAG_C], a_q};
							else
								{ccr_d[FLAG_C], a_d} = {a_q, ccr_q[FLAG_C]};
							ccr_d = nz(ccr_d, a_d);
							ccr_d[FLAG_V] = ccr_d[FLAG_N] ^ ccr_d[FLAG_C];
						end
						OP_MUL:
						begin
							prod = {8'h00, a_q} * {8'h00, b_q};
							{a_d, b_d} = prod;
							ccr_d[FLAG_C] = prod[7];
						end
						default: ;
					endcase
					// Index steps touch only Z
					if (cmd_i.op == OP_INC_X || cmd_i.op == OP_DEC_X)
						ccr_d[FLAG_Z] = (ix_d == WORD_RST);
					if (cmd_i.op == OP_INC_Y || cmd_i.op == OP_DEC_Y)
						ccr_d[FLAG_Z] = (iy_d == WORD_RST);
				end
				else if (reg_we_i)
				begin
					unique case (reg_addr_i)
						REG_ACC_FIRST: a_d = reg_wdata_i[7:0];
						REG_ACC_SECOND: b_d = reg_wdata_i[7:0];
						REG_X_POINTER: ix_d = reg_wdata_i;
						REG_Y_POINTER: iy_d = reg_wdata_i;
						REG_STACK: sp_d = reg_wdata_i;
						REG_PROG_CNT: pc_d = reg_wdata_i;
						REG_FLAGS:
						begin
							ccr_d = reg_wdata_i[7:0];
							ccr_d[FLAG_X] = ccr_q[FLAG_X];
						end
						default: ;
					endcase
				end
			end
		endcase
		// Y-pointer add completes after the extra cycle
		if (st_q == ST_EA_Y && kind_q == OP_ADD_BY)
		begin
			iy_d = iy_q + {8'h00, b_q};
			ea_v_d = 1'b0;
		end
		unique case (reg_addr_i)
			REG_ACC_FIRST: rdata_d = {8'h00, a_q};
			REG_ACC_SECOND: rdata_d = {8'h00, b_q};
			REG_X_POINTER: rdata_d = ix_q;
			REG_Y_POINTER: rdata_d = iy_q;
			REG_STACK: rdata_d = sp_q;
			REG_PROG_CNT: rdata_d = pc_q;
			REG_FLAGS: rdata_d = {8'h00, ccr_q};
			REG_STATUS: rdata_d = {11'h000, stop_q, (st_q == ST_IDLE), st_q};
			default: rdata_d = WORD_RST;
		endcase
		if (!reg_re_i)
			rdata_d = WORD_RST;
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			a_q <= BYTE_RST;
			b_q <= BYTE_RST;
			ix_q <= WORD_RST;
			iy_q <= WORD_RST;
			sp_q <= WORD_RST;
			pc_q <= WORD_RST;
			ccr_q <= FLAGS_RST;
			tgt_q <= WORD_RST;
			ea_q <= WORD_RST;
			rdata_q <= WORD_RST;
			cnt_q <= '0;
			ea_v_q <= 1'b0;
			stop_q <= 1'b0;
			st_q <= ST_BOOT;
			kind_q <= OP_NOP;
		end
		else
		begin
			a_q <= a_d;
			b_q <= b_d;
			ix_q <= ix_d;
			iy_q <= iy_d;
			sp_q <= sp_d;
			pc_q <= pc_d;
			ccr_q <= ccr_d;
			tgt_q <= tgt_d;
			ea_q <= ea_d;
			rdata_q <= rdata_d;
			cnt_q <= cnt_d;
			ea_v_q <= ea_v_d;
			stop_q <= stop_d;
			st_q <= st_d;
			kind_q <= kind_d;
		end
	end

	assign cmd_ready_o = (st_q == ST_IDLE) && !reg_we_i;
	assign mem_o = mem_c;
	assign reg_rdata_o = rdata_q;
	assign ea_o = ea_q;
	assign ea_valid_o = ea_v_q;
	assign stop_o = stop_q;
	assign flags_o = ccr_q;
	assign acc_pair_o = {a_q, b_q};

endmodule

`default_nettype wire

// file: cpm_mem_model.sv
// Flat byte memory on the far side of the programming model.
// Assumes reads are answered in the following cycle, as the design expects.
`timescale 1ns/100ps
`default_nettype none

module cpm_mem_model
	import cpm_pkg::*;
(
	input  wire logic     clk_i,
	input  wire cpm_mem_t mem_i,
	output logic [7:0]    rdata_o
);
	logic [7:0] mem [0:65535];
	logic [7:0] q = 8'h00;

	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'(i) ^ 8'(i >> 8);
	end

	// One space for everything, answered next cycle with no wait
	always @(posedge clk_i)
	begin
		if (mem_i.wr)
			mem[mem_i.addr] <= mem_i.wdata;
		q <= mem_i.rd ? mem[mem_i.addr] : ~q;
	end

	// Outside a read answer the line toggles so stale data never looks valid
	assign rdata_o = q;
endmodule

`default_nettype wire

// file: cpm_programming_model_properties.sv
// Port-level assertions for the programming model.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none

module cpm_programming_model_properties
	import cpm_pkg::*;
(
	input wire logic        ref_clk_i,
	input wire logic        rst_n_i,
	input wire logic [3:0]  reg_addr_i,
	input wire logic        reg_re_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic        cmd_valid_i,
	input wire cpm_cmd_t    cmd_i,
	input wire logic        cmd_ready_o,
	input wire cpm_mem_t    mem_o,
	input wire logic        ea_valid_o,
	input wire logic        stop_o,
	input wire logic [7:0]  flags_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	logic take;
	assign take = cmd_valid_i && cmd_ready_o;

	sequence s_push_pair;
		mem_o.wr ##1 mem_o.wr && mem_o.addr == $past(mem_o.addr) - 16'h0001;
	endsequence
	sequence s_pull_pair;
		mem_o.rd ##1 mem_o.rd && mem_o.addr == $past(mem_o.addr) + 16'h0001;
	endsequence

	property p_flag_read;
		reg_re_i && reg_addr_i == REG_FLAGS |=> reg_rdata_o == {8'h00, $past(flags_o)};
	endproperty
	property p_ea_x;
		take && cmd_i.op == OP_EA_X |=> ea_valid_o;
	endproperty
	property p_ea_y;
		take && cmd_i.op == OP_EA_Y |=> !ea_valid_o ##1 ea_valid_o;
	endproperty
	property p_call;
		take && cmd_i.op inside {OP_JUMP_SUB, OP_BRAN_SUB} |=> s_push_pair;
	endproperty
	property p_ret;
		take && cmd_i.op == OP_RET_SUB |=> s_pull_pair;
	endproperty
	property p_stop_nop;
		take && cmd_i.op == OP_STOP && flags_o[FLAG_S] |=> !stop_o;
	endproperty
	property p_keep;
		take && cmd_i.op inside {OP_ADD_BX, OP_ADD_BY, OP_PUSH_A} |=> $stable(flags_o);
	endproperty
	property p_idx_z;
		take && cmd_i.op inside {OP_INC_X, OP_DEC_X, OP_INC_Y, OP_DEC_Y}
		|=> {flags_o[7:3], flags_o[1:0]} == $past({flags_o[7:3], flags_o[1:0]});
	endproperty
	property p_load;
		take && cmd_i.op == OP_LOAD_A |=> flags_o[FLAG_N] == $past(cmd_i.data[7])
		&& flags_o[FLAG_Z] == ($past(cmd_i.data[7:0]) == 8'h00) && !flags_o[FLAG_V];
	endproperty

	a_flag_read: assert property (p_flag_read) else $error("flags read wrong");
	a_ea_x: assert property (p_ea_x) else $error("ea x late");
	a_ea_y: assert property (p_ea_y) else $error("ea y timing");
	a_call: assert property (p_call) else $error("call push wrong");
	a_ret: assert property (p_ret) else $error("return pull wrong");
	a_stop_nop: assert property (p_stop_nop) else $error("stop not ignored");
	a_keep: assert property (p_keep) else $error("flags changed");
	a_idx_z: assert property (p_idx_z) else $error("index flags");
	a_load: assert property (p_load) else $error("load flags");
endmodule

bind cpm_programming_model cpm_programming_model_properties i_chk (
	.ref_clk_i, .rst_n_i, .reg_addr_i, .reg_re_i, .reg_rdata_o, .cmd_valid_i,
	.cmd_i, .cmd_ready_o, .mem_o, .ea_valid_o, .stop_o, .flags_o
);

`default_nettype wire

// file: cpm_programming_model_tb.sv
// Self-checking bench for the programming model.
// Assumes the memory model answers reads and the bench drives the rest.
`timescale 1ns/100ps
`default_nettype none

module cpm_programming_model_tb
	import cpm_pkg::*;
;
	logic        ref_clk_i, rst_n_i, reg_we_i, reg_re_i, cmd_valid_i, special_mode_i;
	logic [3:0]  reg_addr_i;
	logic [15:0] reg_wdata_i, reg_rdata_o, ea_o, acc_pair_o;
	logic [7:0]  mem_rdata_i, flags_o;
	logic        cmd_ready_o, ea_valid_o, stop_o;
	cpm_cmd_t    cmd_i;
	cpm_cause_t  reset_cause_i;
	cpm_mem_t    mem_o;
	int          miscompares, num_checks;

	cpm_programming_model i_dut (.ref_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
		.reg_we_i, .reg_re_i, .reg_rdata_o, .cmd_valid_i, .cmd_i, .cmd_ready_o,
		.special_mode_i, .reset_cause_i, .mem_o, .mem_rdata_i, .ea_o, .ea_valid_o,
		.stop_o, .flags_o, .acc_pair_o);
	cpm_mem_model i_mem (.clk_i(ref_clk_i), .mem_i(mem_o), .rdata_o(mem_rdata_i));

	function automatic logic [7:0] memv(input logic [15:0] a);
		return a[7:0] ^ a[15:8];
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk_i);
		reg_we_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge ref_clk_i);
		reg_we_i <= 1'b0;
	endtask

	task automatic rchk(input logic [3:0] a, input logic [15:0] e, input string m);
		@(posedge ref_clk_i);
		reg_re_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge ref_clk_i);
		reg_re_i <= 1'b0;
		#1 chk(reg_rdata_o, e, m);
	endtask

	task automatic idle;
		int n;
		n = 0;
		#1;
		while (!cmd_ready_o && n < 60)
		begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end
		chk(16'(cmd_ready_o), 16'h0001, "ready");
	endtask

	task automatic do_cmd(input cpm_op_t op, input logic [15:0] d);
		idle;
		@(posedge ref_clk_i);
		cmd_valid_i <= 1'b1;
		cmd_i <= '{op, d};
		@(posedge ref_clk_i);
		cmd_valid_i <= 1'b0;
		idle;
	endtask

	task automatic do_reset(input logic sm, input cpm_cause_t c);
		@(posedge ref_clk_i);
		rst_n_i <= 1'b0;
		special_mode_i <= sm;
		reset_cause_i <= c;
		repeat (3) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		idle;
	endtask

	task automatic t_vectors;
		logic [15:0] v [6];
		v = '{16'hfffe, 16'hfffc, 16'hfffa, 16'hbffe, 16'hbffc, 16'hbffa};
		for (int i = 0; i < 6; i++)
		begin
			do_reset(i > 2, cpm_cause_t'(i % 3));
			rchk(REG_PROG_CNT, {memv(v[i]), memv(v[i] + 16'h0001)}, "vector");
		end
		rchk(REG_FLAGS, 16'h00d0, "flags reset");
		$display("vector test done");
	endtask

	task automatic t_accum;
		wr(REG_ACC_FIRST, 16'h007f);
		wr(REG_ACC_SECOND, 16'h0001);
		do_cmd(OP_ADD_BA, 16'h0000);
		chk(acc_pair_o, 16'h8001, "add");
		chk(16'(flags_o), 16'h00fa, "add flags");
		wr(REG_ACC_SECOND, 16'h0080);
		do_cmd(OP_CMP_BA, 16'h0000);
		chk(acc_pair_o, 16'h8080, "cmp");
		chk(16'(flags_o[3:0]), 16'h0004, "cmp flags");
		wr(REG_ACC_SECOND, 16'h0081);
		do_cmd(OP_SUB_BA, 16'h0000);
		chk(acc_pair_o, 16'hff81, "sub");
		chk(16'(flags_o[3:0]), 16'h0009, "sub flags");
		$display("accumulator test done");
	endtask

	task automatic t_pointers;
		wr(REG_FLAGS, 16'h00d0);
		wr(REG_X_POINTER, 16'hfff0);
		wr(REG_ACC_SECOND, 16'h0020);
		wr(REG_Y_POINTER, 16'h1234);
		do_cmd(OP_ADD_BX, 16'h0000);
		do_cmd(OP_ADD_BY, 16'h0000);
		rchk(REG_X_POINTER, 16'h0010, "add b x");
		rchk(REG_Y_POINTER, 16'h1254, "add b y");
		chk(16'(flags_o), 16'h00d0, "ptr flags");
		wr(REG_X_POINTER, 16'hffff);
		do_cmd(OP_INC_X, 16'h0000);
		rchk(REG_X_POINTER, 16'h0000, "inc x");
		chk(16'(flags_o), 16'h00d4, "inc flags");
		do_cmd(OP_DEC_Y, 16'h0000);
		chk(16'(flags_o), 16'h00d0, "dec flags");
		wr(REG_X_POINTER, 16'h1000);
		do_cmd(OP_EA_X, 16'h00ff);
		chk(ea_o, 16'h10ff, "ea x");
		do_cmd(OP_EA_Y, 16'h0080);
		chk(ea_o, 16'h12d3, "ea y");
		$display("pointer test done");
	endtask

	task automatic t_flags;
		wr(REG_ACC_FIRST, 16'h0000);
		do_cmd(OP_A_TO_F, 16'h0000);
		chk(16'(flags_o), 16'h0000, "a to flags");
		wr(REG_FLAGS, 16'h00ff);
		rchk(REG_FLAGS, 16'h00bf, "x stays clear");
		do_cmd(OP_F_TO_A, 16'h0000);
		chk(16'(acc_pair_o[15:8]), 16'h00bf, "flags to a");
		do_cmd(OP_STOP, 16'h0000);
		chk(16'(stop_o), 16'h0000, "stop ignored");
		wr(REG_FLAGS, 16'h0000);
		do_cmd(OP_STOP, 16'h0000);
		chk(16'(stop_o), 16'h0001, "stop taken");
		rchk(REG_STATUS, 16'h001a, "status stop");
		do_cmd(OP_LOAD_A, 16'h0080);
		chk(16'(flags_o[3:0]), 16'h0008, "load");
		do_cmd(OP_STORE_A, 16'h0300);
		repeat (2) @(posedge ref_clk_i);
		chk(16'(i_mem.mem[16'h0300]), 16'h0080, "store");
		do_cmd(OP_LOAD_A, 16'h0000);
		chk(16'(flags_o[3:0]), 16'h0004, "load zero");
		wr(REG_ACC_FIRST, 16'h0015);
		wr(REG_ACC_SECOND, 16'h0027);
		do_cmd(OP_ADD_BA, 16'h0000);
		do_cmd(OP_DEC_ADJ, 16'h0000);
		chk(acc_pair_o, 16'h4227, "decimal adjust");
		wr(REG_STATUS, 16'hffff);
		rchk(4'hf, 16'h0000, "unmapped");
		$display("flag test done");
	endtask

	task automatic t_stack;
		wr(REG_STACK, 16'h0200);
		wr(REG_PROG_CNT, 16'h4000);
		do_cmd(OP_JUMP_SUB, 16'h5000);
		rchk(REG_PROG_CNT, 16'h5000, "jsr pc");
		rchk(REG_STACK, 16'h01fe, "jsr sp");
		chk({i_mem.mem[16'h01ff], i_mem.mem[16'h0200]}, 16'h4000, "ret addr");
		do_cmd(OP_RET_SUB, 16'h0000);
		rchk(REG_PROG_CNT, 16'h4000, "rts");
		do_cmd(OP_BRAN_SUB, 16'h00f0);
		rchk(REG_PROG_CNT, 16'h3ff0, "bsr");
		do_cmd(OP_RET_SUB, 16'h0000);
		do_cmd(OP_ADV_PC, 16'h0003);
		rchk(REG_PROG_CNT, 16'h4003, "advance");
		wr(REG_ACC_FIRST, 16'h005a);
		do_cmd(OP_PUSH_A, 16'h0000);
		wr(REG_ACC_FIRST, 16'h0000);
		do_cmd(OP_PULL_A, 16'h0000);
		chk(16'(acc_pair_o[15:8]), 16'h005a, "pull");
		rchk(REG_STACK, 16'h0200, "pull sp");
		wr(REG_X_POINTER, 16'h1111);
		wr(REG_FLAGS, 16'h0000);
		do_cmd(OP_INT_MASK, 16'h3000);
		rchk(REG_STACK, 16'h01f7, "int sp");
		chk(16'(i_mem.mem[16'h01fb]), 16'h0011, "stacked x");
		chk(16'(i_mem.mem[16'h01f8]), 16'h0000, "stacked flags");
		chk({i_mem.mem[16'h01ff], i_mem.mem[16'h0200]}, 16'h4003, "stacked pc");
		rchk(REG_PROG_CNT, {memv(16'h3000), memv(16'h3001)}, "int vector");
		chk(16'(flags_o[FLAG_I]), 16'h0001, "mask set");
		wr(REG_X_POINTER, 16'h0000);
		do_cmd(OP_RET_INT, 16'h0000);
		rchk(REG_X_POINTER, 16'h1111, "rti x");
		rchk(REG_PROG_CNT, 16'h4003, "rti pc");
		chk(16'(flags_o), 16'h0000, "rti flags");
		$display("stack test done");
	endtask

	task automatic t_more;
		wr(REG_ACC_FIRST, 16'h0081);
		wr(REG_FLAGS, 16'h0000);
		do_cmd(OP_ROR_A, 16'h0000);
		chk({acc_pair_o[15:8], flags_o}, 16'h4003, "ror");
		do_cmd(OP_ROL_A, 16'h0000);
		chk({acc_pair_o[15:8], flags_o}, 16'h810a, "rol");
		wr(REG_ACC_FIRST, 16'h000c);
		wr(REG_ACC_SECOND, 16'h000b);
		do_cmd(OP_MUL, 16'h0000);
		chk(acc_pair_o, 16'h0084, "mul");
		chk(16'(flags_o), 16'h000b, "mul carry");
		wr(REG_Y_POINTER, 16'hffff);
		do_cmd(OP_INC_Y, 16'h0000);
		chk(16'(flags_o), 16'h000f, "inc y");
		wr(REG_X_POINTER, 16'h0005);
		do_cmd(OP_DEC_X, 16'h0000);
		chk(16'(flags_o), 16'h000b, "dec x");
		wr(REG_FLAGS, 16'h0000);
		do_cmd(OP_INT_NMI, 16'h3000);
		chk(16'(flags_o), 16'h0050, "nmi masks");
		do_cmd(OP_RET_INT, 16'h0000);
		chk(16'(flags_o), 16'h0000, "rti clears x");
		$display("extra test done");
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	initial
	begin
		#200000;
		miscompares++;
		complete_run;
	end

	initial
	begin
		rst_n_i = 1'b0;
		reg_we_i = 1'b0;
		reg_re_i = 1'b0;
		reg_addr_i = 4'h0;
		reg_wdata_i = 16'h0000;
		cmd_valid_i = 1'b0;
		cmd_i = '{OP_NOP, 16'h0000};
		special_mode_i = 1'b0;
		reset_cause_i = CAUSE_POR_PIN;
		t_vectors;
		t_accum;
		t_pointers;
		t_flags;
		t_stack;
		t_more;
		complete_run;
	end
endmodule

`default_nettype wire
